/* File: inc/sram_pkg.sv */
//------------------------------------------------------------
// Summary of operation
// - Selected only with primary select low, expand high high, expand low low.
// - Selects are sampled only on edges where an address strobe is acted on.
// - Processor strobe is ignored while primary select is high.
// - Either strobe low with the chip selected loads the address register and seeds the counter.
// - With both strobes low only the processor strobe is acted on.
// - Advance low at an edge steps the burst counter.
// - Data pins drive while output enable is low, float while high.
// - First read clock after deselect keeps the pins floating.
// - Write data is captured into an input register at the clock edge.
// - Read data appears one registered stage after its address.
// - Sleep high enters a contents-keeping sleep; low means normal.
// - Order strap low gives linear bursts, high gives interleaved.
// - The burst counter is two bits, cleared on load; the low address bits give the burst start.
// - Global write low writes all four bytes.
// - A byte is written when byte gate and its lane select are low.
//------------------------------------------------------------
package sram_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int CNT_W = 2;
    localparam int WBUF_DEPTH = 8;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
    localparam logic ORDER_RESET = 1'b1;
    typedef enum logic [1:0] {ST_DESEL, ST_SEL, ST_SLEEP} acc_state_t;
endpackage : sram_pkg

/* File: verilog/burst_sram.sv */
`timescale 1ns/1ps
module wbuf_fifo #(
    parameter int W = 54,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW:0] ONE_C = (PW+1)'(1);
    localparam logic [PW-1:0] ONE_P = PW'(1);
    logic [W-1:0] store [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_depth_check
        $error("wbuf_fifo depth must be a power of two of at least two");
    end

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = store[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + ONE_P : wr_q;
        rd_d = pop ? rd_q + ONE_P : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + ONE_C;
        else if (pop && !push)
            cnt_d = cnt_q - ONE_C;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            store[wr_q] <= in_data;
    end
endmodule : wbuf_fifo

module burst_sram #(
    parameter int AW = sram_pkg::ADDR_W,
    parameter int DEPTH_W = sram_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [AW-1:0] addr,
    input wire logic select_primary_n,
    input wire logic select_expand_high,
    input wire logic select_expand_low_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic all_bytes_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [sram_pkg::LANES-1:0] byte_lane_select_n,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order,
    input wire logic [sram_pkg::DATA_W-1:0] dq_in,
    output logic [sram_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic sleep_active,
    output logic write_buffer_full
);
    import sram_pkg::*;
    localparam int EW = AW + DATA_W + LANES;

    if (DEPTH_W > AW || DEPTH_W < CNT_W)
    begin : g_depth_check
        $error("burst_sram depth width out of range");
    end

    function automatic logic [CNT_W-1:0] burst_offset(input logic [CNT_W-1:0] start,
        input logic [CNT_W-1:0] count, input logic interleave);
        burst_offset = interleave ? (start ^ count) : CNT_W'(start + count);
    endfunction : burst_offset

    //--------------------------------------------------------
    // Sleep synchroniser and order strap
    //--------------------------------------------------------
    logic sleep_s1_q, sleep_s2_q, order_seen_q, interleave_q, interleave_d;
    always_comb
    begin
        interleave_d = order_seen_q ? interleave_q : burst_order;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
            order_seen_q <= 1'b0;
            interleave_q <= ORDER_RESET;
        end
        else
        begin
            sleep_s1_q <= sleep_request;
            sleep_s2_q <= sleep_s1_q;
            order_seen_q <= 1'b1;
            interleave_q <= interleave_d;
        end
    end

    //--------------------------------------------------------
    // Address load and burst counter
    //--------------------------------------------------------
    acc_state_t state_q, state_d;
    logic [AW-1:0] addr_q, addr_d, cur_addr;
    logic [CNT_W-1:0] count_q, count_d;
    logic awake, proc_hit, load, sel_in, acc, sleep_q, sleep_d;
    logic [LANES-1:0] wmask;

    assign awake = state_q != ST_SLEEP;
    assign proc_hit = !proc_addr_strobe_n && !select_primary_n;
    assign load = awake && (proc_hit || !ctrl_addr_strobe_n);
    assign sel_in = !select_primary_n && select_expand_high && !select_expand_low_n;

    always_comb
    begin
        state_d = state_q;
        addr_d = addr_q;
        count_d = count_q;
        if (sleep_s2_q)
            state_d = ST_SLEEP;
        else if (!awake)
            state_d = ST_DESEL;
        else if (load)
        begin
            state_d = sel_in ? ST_SEL : ST_DESEL;
            if (sel_in)
            begin
                addr_d = addr;
                count_d = CNT_ZERO;
            end
        end
        else if (state_q == ST_SEL && !burst_advance_n)
            count_d = count_q + CNT_STEP;
        cur_addr = {addr_d[AW-1:CNT_W],
            burst_offset(addr_d[CNT_W-1:0], count_d, interleave_q)};
        acc = awake && !sleep_s2_q && state_d == ST_SEL;
        if (!acc || (load && proc_hit))
            wmask = LANES_NONE;
        else if (!all_bytes_write_n)
            wmask = LANES_ALL;
        else if (!byte_write_gate_n)
            wmask = ~byte_lane_select_n;
        else
            wmask = LANES_NONE;
        sleep_d = state_d == ST_SLEEP;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_DESEL;
            addr_q <= '0;
            count_q <= CNT_ZERO;
            sleep_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            count_q <= count_d;
            sleep_q <= sleep_d;
        end
    end

    //--------------------------------------------------------
    // Input register, read stage and pin drive
    //--------------------------------------------------------
    logic [DATA_W-1:0] din_q, dout_q, dout_d, rd_word;
    logic [AW-1:0] waddr_q, rd_addr_q;
    logic [LANES-1:0] wmask_q, wmask_d;
    logic rd_en_q, rd_en_d, first_q, first_d, oe_q, oe_d, full_q;
    logic in_ready, drain_valid, drain_ready;
    logic [EW-1:0] drain_data;
    logic [DATA_W-1:0] mem [2**DEPTH_W];

    assign rd_word = mem[rd_addr_q[DEPTH_W-1:0]];

    always_comb
    begin
        wmask_d = wmask;
        rd_en_d = acc && wmask == LANES_NONE;
        first_d = rd_en_d && state_q != ST_SEL;
        dout_d = rd_en_q ? rd_word : dout_q;
        oe_d = rd_en_q && !first_q && !out_enable_n && awake && !sleep_s2_q
            && !(load && !sel_in) && wmask == LANES_NONE;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            din_q <= '0;
            waddr_q <= '0;
            wmask_q <= LANES_NONE;
            rd_addr_q <= '0;
            rd_en_q <= 1'b0;
            first_q <= 1'b0;
            dout_q <= '0;
            oe_q <= 1'b0;
            full_q <= 1'b0;
        end
        else
        begin
            din_q <= dq_in;
            waddr_q <= cur_addr;
            wmask_q <= wmask_d;
            rd_addr_q <= cur_addr;
            rd_en_q <= rd_en_d;
            first_q <= first_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            full_q <= !in_ready;
        end
    end

    assign dq_out = dout_q;
    assign dq_oe = oe_q;
    assign sleep_active = sleep_q;
    assign write_buffer_full = full_q;

    //--------------------------------------------------------
    // Write buffer and array
    //--------------------------------------------------------
    // Array port goes to reads first; sleep also holds pending writes
    assign drain_ready = awake && !rd_en_q;

    wbuf_fifo #(.W(EW), .DEPTH(WBUF_DEPTH)) u_wbuf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(wmask_q != LANES_NONE),
        .in_ready(in_ready),
        .in_data({waddr_q, wmask_q, din_q}),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    always_ff @(posedge clk)
    begin
        if (drain_valid && drain_ready)
        begin
            for (int b = 0; b < LANES; b++)
            begin
                if (drain_data[DATA_W+b])
                    mem[drain_data[DATA_W+LANES+:DEPTH_W]][b*8+:8] <= drain_data[b*8+:8];
            end
        end
    end

    //--------------------------------------------------------
    // Checks
    //--------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_select_decode: assert property (load && !sel_in && !sleep_s2_q |=> state_q == ST_DESEL)
        else $error("deselect not taken");
    chk_select_idle: assert property (state_q == ST_SEL && !load && !sleep_s2_q
        |=> state_q == ST_SEL)
        else $error("selects sampled without a load");
    chk_proc_ignored: assert property (awake && select_primary_n && !proc_addr_strobe_n
        && ctrl_addr_strobe_n |=> $stable(addr_q))
        else $error("processor strobe not ignored");
    chk_addr_load: assert property (load && sel_in && !sleep_s2_q
        |=> addr_q == $past(addr) && count_q == CNT_ZERO)
        else $error("address not loaded");
    chk_proc_wins: assert property (proc_hit && !ctrl_addr_strobe_n && sel_in && awake
        && !sleep_s2_q |=> wmask_q == LANES_NONE)
        else $error("controller strobe acted on");
    chk_burst_step: assert property (state_q == ST_SEL && awake && !sleep_s2_q && !load
        && !burst_advance_n |=> count_q == $past(count_q) + CNT_STEP)
        else $error("counter did not step");
    chk_oe_float: assert property (out_enable_n |=> !dq_oe)
        else $error("pins driven with output enable high");
    chk_first_mask: assert property (first_q |=> !dq_oe)
        else $error("first read after deselect driven");
    chk_read_stage: assert property (rd_en_q |=> dq_out == $past(rd_word))
        else $error("read data not from addressed word");
    chk_sleep_entry: assert property ($rose(sleep_s2_q) |=> sleep_active ##1 !dq_oe)
        else $error("sleep not entered");
    chk_global_write: assert property (acc && !all_bytes_write_n && !(load && proc_hit)
        |=> wmask_q == LANES_ALL)
        else $error("global write not all lanes");
    chk_desel_float: assert property (load && !sel_in |=> !dq_oe)
        else $error("pins driven after deselect");

    cov_full_burst: cover property (load && sel_in ##1 (!burst_advance_n && !load) [*3]);
    cov_ctrl_write: cover property (!ctrl_addr_strobe_n && proc_addr_strobe_n && sel_in
        && wmask != LANES_NONE);
    cov_sleep: cover property (sleep_active ##1 !sleep_active);
    cov_buf_full: cover property (write_buffer_full);
endmodule : burst_sram

/* File: tb/host_bus_model.sv */
`timescale 1ns/1ps
//------------------------------------------------------------
// Far-side data bus
//------------------------------------------------------------
module host_bus_model (
    input wire logic clk,
    input wire logic [sram_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic [sram_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_drive,
    output logic [sram_pkg::DATA_W-1:0] dq_in
);
    import sram_pkg::*;
    logic [DATA_W-1:0] last_q = 32'h0;
    // A floating bus shows the inverse of its last level, never a held value
    always_comb
    begin
        if (wr_drive)
            dq_in = wr_data;
        else if (dq_oe)
            dq_in = dq_out;
        else
            dq_in = ~last_q;
    end
    always_ff @(posedge clk)
    begin
        last_q <= dq_in;
    end
endmodule : host_bus_model

/* File: tb/tb_burst_sram.sv */
`timescale 1ns/1ps
//------------------------------------------------------------
// Pin-level bench
//------------------------------------------------------------
module tb_burst_sram;
    import sram_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0;
    logic [17:0] addr = 18'h0;
    logic select_primary_n = 1'b0, select_expand_high = 1'b1, select_expand_low_n = 1'b0;
    logic proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_advance_n = 1'b1;
    logic all_bytes_write_n = 1'b1, byte_write_gate_n = 1'b1, out_enable_n = 1'b0;
    logic [LANES-1:0] byte_lane_select_n = 4'hF;
    logic sleep_request = 1'b0, burst_order = 1'b1, wr_drive = 1'b0;
    logic [DATA_W-1:0] dq_in, dq_out, wr_data = 32'h0;
    logic dq_oe, sleep_active, write_buffer_full;
    logic [DATA_W-1:0] mem [256];
    int error_cnt = 0, checks_done = 0;

    burst_sram #(.DEPTH_W(8)) DUT (.clk, .rst_b, .addr, .select_primary_n,
        .select_expand_high, .select_expand_low_n, .proc_addr_strobe_n,
        .ctrl_addr_strobe_n, .burst_advance_n, .all_bytes_write_n, .byte_write_gate_n,
        .byte_lane_select_n, .out_enable_n, .sleep_request, .burst_order, .dq_in,
        .dq_out, .dq_oe, .sleep_active, .write_buffer_full);
    host_bus_model far (.clk, .dq_out, .dq_oe, .wr_data, .wr_drive, .dq_in);

    always #25 clk = ~clk;

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset(input logic ord);
        @(posedge clk);
        rst_b <= 1'b0;
        burst_order <= ord;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    // Controller-strobe write; p also lowers the processor strobe
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic g,
                      input logic b, input logic [3:0] ln, input logic p);
        @(posedge clk);
        ctrl_addr_strobe_n <= 1'b0;
        proc_addr_strobe_n <= !p;
        select_primary_n <= 1'b0;
        addr <= a;
        all_bytes_write_n <= g;
        byte_write_gate_n <= b;
        byte_lane_select_n <= ln;
        out_enable_n <= 1'b1;
        wr_data <= d;
        wr_drive <= 1'b1;
        for (int i = 0; i < 4; i++)
            if (!p && (!g || (!b && !ln[i])))
                mem[a[7:0]][8*i+:8] = d[8*i+:8];
        @(posedge clk);
        ctrl_addr_strobe_n <= 1'b1;
        proc_addr_strobe_n <= 1'b1;
        all_bytes_write_n <= 1'b1;
        byte_write_gate_n <= 1'b1;
        byte_lane_select_n <= 4'hF;
        wr_drive <= 1'b0;
    endtask : wr

    // Deselect, then a processor-strobe burst of n beats
    task automatic rd(input logic [17:0] a, input int n, input logic oe);
        logic [1:0] w;
        @(posedge clk);
        ctrl_addr_strobe_n <= 1'b0;
        select_primary_n <= 1'b1;
        @(posedge clk);
        ctrl_addr_strobe_n <= 1'b1;
        select_primary_n <= 1'b0;
        proc_addr_strobe_n <= 1'b0;
        addr <= a;
        out_enable_n <= oe;
        @(negedge clk);
        check(dq_oe, 1'b0);
        @(posedge clk);
        proc_addr_strobe_n <= 1'b1;
        select_primary_n <= 1'b1;
        burst_advance_n <= (n < 2);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            burst_advance_n <= (k + 3 > n);
            @(negedge clk);
            w = burst_order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
            check(dq_out, mem[{a[7:2], w}]);
            check(dq_oe, k > 0 && !oe);
        end
    endtask : rd

    initial
    begin
        #200us;
        error_cnt++;
        conclude();
    end

    initial
    begin
        do_reset(1'b1);
        for (int i = 0; i < 8; i++)
            wr(18'h10 + 18'(i), {24'hA5C3E1, 8'(i)}, 1'b0, 1'b1, 4'hF, 1'b0);
        wr(18'h12, 32'h11223344, 1'b1, 1'b0, 4'hA, 1'b0);
        wr(18'h13, 32'h0BAD0BAD, 1'b1, 1'b1, 4'h0, 1'b0);
        wr(18'h14, 32'hDEADBEEF, 1'b0, 1'b1, 4'hF, 1'b1);
        repeat (12) @(posedge clk);
        @(negedge clk);
        check(write_buffer_full, 1'b0);
        rd(18'h12, 4, 1'b0);
        @(posedge clk);
        proc_addr_strobe_n <= 1'b0;
        addr <= 18'h16;
        @(posedge clk);
        proc_addr_strobe_n <= 1'b1;
        @(negedge clk);
        check(dq_oe, 1'b1);
        check(dq_out, mem[8'h11]);
        rd(18'h17, 2, 1'b1);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk);
            sleep_request <= v[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            check(sleep_active, !v[0]);
            @(posedge clk);
            @(negedge clk);
            check(sleep_active, v[0]);
            if (v == 1)
            begin
                wr(18'h11, 32'h5A5A5A5A, 1'b0, 1'b1, 4'hF, 1'b0);
                mem[8'h11] = {24'hA5C3E1, 8'h01};
            end
        end
        repeat (12) @(posedge clk);
        do_reset(1'b0);
        rd(18'h13, 4, 1'b0);
        conclude();
    end
endmodule : tb_burst_sram
